// *** ecl_cfg_loader.sv ***
// ecl_cfg_loader: copies configuration memory words 0ch..20h into per-port register images
// assumes a memory reader on clk_i giving one word per mem_valid_i cycle, signature word first
//
// Overview of operation
// - check signature word at 00h first; word 0ch low bits give payload support.
// - capability word bit 12 sets link capability bit 19 on every port.
// - capability word bit 13 sets control register 8ch bit 1 on every port.
// - capability word bit 14 sets device capability two bit 12 on every port.
// - capability word bit 15 sets control register 8ch bit 3 on every port.
// - word 0eh bits 14:0 go to margin drive register bits 14:0.
// - word 0eh bit 15 sets device capability two bit 18.
// - word 10h bits 14:0 go to nominal drive register bits 30:16.
// - word 10h bit 15 sets control register 8ch bit 31.
// - word 12h bits 14:0 go to emphasis register bits 30:16.
// - word 12h bit 15 sets interrupt pin bit 8 on every port but port 0.
// - word 14h bits 6:0 go to latency register bits 6:0.
// - word 14h bits 11:7 go to delta register bits 19:15.
// - word 14h bits 12,13,14 set control register bits 2, 7, 12.
// - words 16h and 18h fill low and high vendor control a halves.
// - word 1ah fills vendor control b 15:0; word 1ch low byte fills 23:16.
// - word 1ch high byte goes to buffer control bits 23:16.
// - word 1eh bits 15:12 go to control register bits 29:26.
// - word 20h low byte goes to emphasis register bits 7:0, port 0 only.
`timescale 1ns/100ps
module ecl_cfg_loader #(
   parameter int NUM_PORTS = ecl_pkg::NUM_PORTS_DEF,
   // signature value is arbitrary
   parameter logic [ecl_pkg::MEM_W-1:0] SIGNATURE = 16'hc3a5
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // word stream from the memory reader
   input wire logic mem_valid_i,
   input wire logic [ecl_pkg::MEM_AW-1:0] mem_addr_i,
   input wire logic [ecl_pkg::MEM_W-1:0] mem_data_i,
   input wire logic load_start_i,
   // loader status
   output logic load_active_o,
   output logic load_done_o,
   output logic sig_bad_o,
   output logic [ecl_pkg::W_PAY-1:0] payload_size_o,
   // configuration read
   input wire logic rd_req_i,
   input wire logic [ecl_pkg::RD_PW-1:0] rd_port_i,
   input wire logic [7:0] rd_offset_i,
   output logic rd_valid_o,
   output logic [ecl_pkg::REG_W-1:0] rd_data_o,
   // per-port register images
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] interrupt_pin_info_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] phy_nominal_drive_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] phy_emphasis_fts_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] phy_latency_detect_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] vendor_phy_ctrl_a_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] vendor_phy_ctrl_b_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] transaction_layer_ctrl_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] phy_delta_params_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] phy_margin_drive_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] refclk_buffer_ctrl_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] link_capability_o,
   output logic [NUM_PORTS-1:0][ecl_pkg::REG_W-1:0] device_capability_two_o
);
   import ecl_pkg::*;

   generate
      if (NUM_PORTS < 2 || NUM_PORTS > (1 << RD_PW)) begin : g_bad_ports
         $error("NUM_PORTS must lie between 2 and 8");
      end
   endgenerate

   typedef struct packed {
      ecl_state_t st;
      logic [W_PAY-1:0] payload;
   } ecl_ldr_state_t;

   ecl_ldr_state_t q;
   ecl_ldr_state_t next_q;
   logic apply;
   logic [NUM_REGS-1:0][REG_W-1:0] mask;
   logic [NUM_REGS-1:0][REG_W-1:0] val;
   logic [NUM_PORTS-1:0][NUM_REGS-1:0][REG_W-1:0] port_regs;

   // words are used only once the signature has matched
   assign apply = mem_valid_i && (q.st == ECL_LOAD);

   always_comb begin
      next_q = q;
      unique case (q.st)
         ECL_WAIT_SIG: begin
            if (mem_valid_i && mem_addr_i == W_SIG) begin
               next_q.st = (mem_data_i == SIGNATURE) ? ECL_LOAD : ECL_BAD;
            end
         end
         ECL_LOAD: begin
            if (mem_valid_i && mem_addr_i == W_CAP) begin
               next_q.payload = mem_data_i[LO_POS +: W_PAY];
            end
            if (mem_valid_i && mem_addr_i == W_FTS) begin
               next_q.st = ECL_DONE;
            end
         end
         ECL_DONE, ECL_BAD: begin
            if (load_start_i) begin
               next_q.st = ECL_WAIT_SIG;
            end
         end
      endcase
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{st: ECL_WAIT_SIG, payload: '0};
      end else begin
         q <= next_q;
      end
   end

   // decode one memory word into masked field updates
   always_comb begin
      mask = '0;
      val = '0;
      case (mem_addr_i)
         W_CAP: begin
            mask[R_LNK][CC_SDN] = 1'b1;
            val[R_LNK][CC_SDN] = mem_data_i[S_SDN];
            mask[R_TL][TL_PMDS] = 1'b1;
            val[R_TL][TL_PMDS] = mem_data_i[S_PMDS];
            mask[R_DC2][DC2_LTR] = 1'b1;
            val[R_DC2][DC2_LTR] = mem_data_i[S_LTR];
            mask[R_TL][TL_4KB] = 1'b1;
            val[R_TL][TL_4KB] = mem_data_i[S_TOP];
         end
         W_MGN: begin
            mask[R_MGN][LO_POS +: W_TRI] = '1;
            val[R_MGN][LO_POS +: W_TRI] = mem_data_i[LO_POS +: W_TRI];
            mask[R_DC2][DC2_OBFF] = 1'b1;
            val[R_DC2][DC2_OBFF] = mem_data_i[S_TOP];
         end
         W_NOM: begin
            mask[R_NOM][HI_POS +: W_TRI] = '1;
            val[R_NOM][HI_POS +: W_TRI] = mem_data_i[LO_POS +: W_TRI];
            mask[R_TL][TL_G2] = 1'b1;
            val[R_TL][TL_G2] = mem_data_i[S_TOP];
         end
         W_EMP: begin
            mask[R_EMP][HI_POS +: W_TRI] = '1;
            val[R_EMP][HI_POS +: W_TRI] = mem_data_i[LO_POS +: W_TRI];
            mask[R_INTR][INT_PIN] = 1'b1;
            val[R_INTR][INT_PIN] = mem_data_i[S_TOP];
         end
         W_LAT: begin
            mask[R_LAT][LO_POS +: W_LATF] = '1;
            val[R_LAT][LO_POS +: W_LATF] = mem_data_i[LO_POS +: W_LATF];
            mask[R_LAT][RDET_POS +: W_RDET] = '1;
            val[R_LAT][RDET_POS +: W_RDET] = mem_data_i[S_RDET +: W_RDET];
            mask[R_DLT][HDLT_POS +: W_HDLT] = '1;
            val[R_DLT][HDLT_POS +: W_HDLT] = mem_data_i[S_HDLT +: W_HDLT];
            mask[R_TL][TL_ABT] = 1'b1;
            val[R_TL][TL_ABT] = mem_data_i[S_ABT];
            mask[R_TL][TL_GIDLE] = 1'b1;
            val[R_TL][TL_GIDLE] = mem_data_i[S_GIDLE];
            mask[R_TL][TL_ARB] = 1'b1;
            val[R_TL][TL_ARB] = mem_data_i[S_ARB];
         end
         W_VA_LO: begin
            mask[R_VA][LO_POS +: MEM_W] = '1;
            val[R_VA][LO_POS +: MEM_W] = mem_data_i;
         end
         W_VA_HI: begin
            mask[R_VA][HI_POS +: MEM_W] = '1;
            val[R_VA][HI_POS +: MEM_W] = mem_data_i;
         end
         W_VB_LO: begin
            mask[R_VB][LO_POS +: MEM_W] = '1;
            val[R_VB][LO_POS +: MEM_W] = mem_data_i;
         end
         W_VB_HI: begin
            mask[R_VB][HI_POS +: W_BYTE] = '1;
            val[R_VB][HI_POS +: W_BYTE] = mem_data_i[LO_POS +: W_BYTE];
            mask[R_BUF][HI_POS +: W_BYTE] = '1;
            val[R_BUF][HI_POS +: W_BYTE] = mem_data_i[S_BUF +: W_BYTE];
         end
         W_DLT: begin
            mask[R_DLT][DLT_POS +: W_DLTF] = '1;
            val[R_DLT][DLT_POS +: W_DLTF] = mem_data_i[LO_POS +: W_DLTF];
            mask[R_TL][TL_MAC +: W_MACF] = '1;
            val[R_TL][TL_MAC +: W_MACF] = mem_data_i[S_MAC +: W_MACF];
         end
         W_FTS: begin
            mask[R_EMP][LO_POS +: W_BYTE] = '1;
            val[R_EMP][LO_POS +: W_BYTE] = mem_data_i[LO_POS +: W_BYTE];
         end
         default: begin
            mask = '0;
         end
      endcase
   end

   // one image per port, all fed the same update
   generate
      for (genvar p = 0; p < NUM_PORTS; p++) begin : g_port
         ecl_port_regs #(
            .PORT(p)
         ) u_port (
            .clk_i(clk_i),
            .rst_i(rst_i),
            .apply_i(apply),
            .mask_i(mask),
            .val_i(val),
            .regs_o(port_regs[p])
         );
         assign interrupt_pin_info_o[p] = port_regs[p][R_INTR];
         assign phy_nominal_drive_o[p] = port_regs[p][R_NOM];
         assign phy_emphasis_fts_o[p] = port_regs[p][R_EMP];
         assign phy_latency_detect_o[p] = port_regs[p][R_LAT];
         assign vendor_phy_ctrl_a_o[p] = port_regs[p][R_VA];
         assign vendor_phy_ctrl_b_o[p] = port_regs[p][R_VB];
         assign transaction_layer_ctrl_o[p] = port_regs[p][R_TL];
         assign phy_delta_params_o[p] = port_regs[p][R_DLT];
         assign phy_margin_drive_o[p] = port_regs[p][R_MGN];
         assign refclk_buffer_ctrl_o[p] = port_regs[p][R_BUF];
         assign link_capability_o[p] = port_regs[p][R_LNK];
         assign device_capability_two_o[p] = port_regs[p][R_DC2];
      end
   endgenerate

   ecl_rd_port #(
      .NUM_PORTS(NUM_PORTS)
   ) u_rd (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .rd_req_i(rd_req_i),
      .rd_port_i(rd_port_i),
      .rd_offset_i(rd_offset_i),
      .regs_i(port_regs),
      .rd_valid_o(rd_valid_o),
      .rd_data_o(rd_data_o)
   );

   assign load_active_o = (q.st == ECL_LOAD);
   assign load_done_o = (q.st == ECL_DONE);
   assign sig_bad_o = (q.st == ECL_BAD);
   assign payload_size_o = q.payload;

   // helper for the checks below: the word seen one cycle earlier
   logic [MEM_W-1:0] prev_data;
   always_ff @(posedge clk_i) begin
      prev_data <= mem_data_i;
   end

   localparam int LP = NUM_PORTS - 1;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (rst_i);

   sequence s_sig_seen;
      mem_valid_i && (q.st == ECL_WAIT_SIG) && (mem_addr_i == W_SIG);
   endsequence

   sequence s_word(logic [MEM_AW-1:0] a);
      mem_valid_i && load_active_o && (mem_addr_i == a);
   endsequence

   a_sig_accept: assert property (s_sig_seen ##0 (mem_data_i == SIGNATURE) |=> load_active_o)
      else $error("matching signature did not start the load");
   a_sig_reject: assert property (s_sig_seen ##0 (mem_data_i != SIGNATURE) |=> sig_bad_o ##1 !load_active_o)
      else $error("bad signature was not refused");
   a_payload_copy: assert property (s_word(W_CAP) |=> payload_size_o == prev_data[W_PAY-1:0])
      else $error("payload support bits not captured");
   a_surprise_down: assert property (s_word(W_CAP) |=>
         link_capability_o[0][CC_SDN] == prev_data[S_SDN] && link_capability_o[LP][CC_SDN] == prev_data[S_SDN])
      else $error("surprise down enable not copied");
   a_pm_data_sel: assert property (s_word(W_CAP) |=> transaction_layer_ctrl_o[LP][TL_PMDS] == prev_data[S_PMDS])
      else $error("data select write enable not copied");
   a_ltr_enable: assert property (s_word(W_CAP) |=> device_capability_two_o[0][DC2_LTR] == prev_data[S_LTR])
      else $error("ltr enable not copied");
   a_boundary_chk: assert property (s_word(W_CAP) |=> transaction_layer_ctrl_o[0][TL_4KB] == prev_data[S_TOP])
      else $error("boundary check enable not copied");
   a_margin_drive: assert property (s_word(W_MGN) |=>
         phy_margin_drive_o[LP][W_TRI-1:0] == prev_data[W_TRI-1:0])
      else $error("margin drive levels not loaded");
   a_obff_enable: assert property (s_word(W_MGN) |=> device_capability_two_o[LP][DC2_OBFF] == prev_data[S_TOP])
      else $error("obff enable not copied");
   a_nominal_drive: assert property (s_word(W_NOM) |=>
         phy_nominal_drive_o[0][HI_POS +: W_TRI] == prev_data[W_TRI-1:0])
      else $error("nominal drive levels not loaded");
   a_gen2_mode: assert property (s_word(W_NOM) |=> transaction_layer_ctrl_o[0][TL_G2] == prev_data[S_TOP])
      else $error("second generation mode select not copied");
   a_post_cursor: assert property (s_word(W_EMP) |=>
         phy_emphasis_fts_o[LP][HI_POS +: W_TRI] == prev_data[W_TRI-1:0])
      else $error("post cursor fields not loaded");
   a_intr_pin: assert property (s_word(W_EMP) |=>
         interrupt_pin_info_o[1][INT_PIN] == prev_data[S_TOP] && $stable(interrupt_pin_info_o[0]))
      else $error("interrupt pin bit wrong on a port");
   a_latency_det: assert property (s_word(W_LAT) |=>
         phy_latency_detect_o[0][W_LATF+W_RDET-1:0] == prev_data[W_LATF+W_RDET-1:0])
      else $error("latency or detect time not loaded");
   a_half_delta: assert property (s_word(W_LAT) |=>
         phy_delta_params_o[LP][HDLT_POS +: W_HDLT] == prev_data[S_HDLT +: W_HDLT])
      else $error("half swing delta not loaded");
   a_arb_bits: assert property (s_word(W_LAT) |=>
         transaction_layer_ctrl_o[0][TL_ABT] == prev_data[S_ABT]
         && transaction_layer_ctrl_o[0][TL_GIDLE] == prev_data[S_GIDLE]
         && transaction_layer_ctrl_o[0][TL_ARB] == prev_data[S_ARB])
      else $error("arbiter control bits not loaded");
   a_vendor_a: assert property (s_word(W_VA_LO) ##1 s_word(W_VA_HI) |=>
         vendor_phy_ctrl_a_o[0] == {prev_data, $past(prev_data)})
      else $error("vendor control a halves misplaced");
   a_vendor_b: assert property (s_word(W_VB_HI) |=>
         vendor_phy_ctrl_b_o[LP][HI_POS +: W_BYTE] == prev_data[W_BYTE-1:0])
      else $error("vendor control b upper byte not loaded");
   a_vendor_b_lo: assert property (s_word(W_VB_LO) |=> vendor_phy_ctrl_b_o[0][MEM_W-1:0] == prev_data)
      else $error("vendor control b low half not loaded");
   a_refclk_buf: assert property (s_word(W_VB_HI) |=>
         refclk_buffer_ctrl_o[0][HI_POS +: W_BYTE] == prev_data[S_BUF +: W_BYTE])
      else $error("buffer control not loaded");
   a_delta_fields: assert property (s_word(W_DLT) |=>
         phy_delta_params_o[0][DLT_POS +: W_DLTF] == prev_data[W_DLTF-1:0])
      else $error("drive and emphasis deltas not loaded");
   a_mac_ctrl: assert property (s_word(W_DLT) |=>
         transaction_layer_ctrl_o[LP][TL_MAC +: W_MACF] == prev_data[S_MAC +: W_MACF])
      else $error("mac control field not loaded");
   a_fts_port0: assert property (s_word(W_FTS) |=>
         phy_emphasis_fts_o[0][W_BYTE-1:0] == prev_data[W_BYTE-1:0] && $stable(phy_emphasis_fts_o[1]) && load_done_o)
      else $error("fast training count wrong or load not finished");
   a_hold_idle: assert property (!(mem_valid_i && load_active_o) |=>
         $stable(transaction_layer_ctrl_o) && $stable(link_capability_o))
      else $error("register image changed without a loaded word");
   a_ports_agree: assert property (load_done_o |->
         phy_delta_params_o[0] == phy_delta_params_o[LP] && vendor_phy_ctrl_b_o[0] == vendor_phy_ctrl_b_o[LP])
      else $error("ports disagree after load");
   a_unmapped_bits: assert property (vendor_phy_ctrl_b_o[0][REG_W-1:HI_POS+W_BYTE] == '0
         && refclk_buffer_ctrl_o[LP][HI_POS-1:0] == '0)
      else $error("unmapped bits left their reset value");
   a_restart: assert property ((load_done_o || sig_bad_o) && load_start_i |=>
         !load_done_o && !sig_bad_o && !load_active_o)
      else $error("restart did not return to signature wait");
   a_read_turn: assert property (rd_req_i && rd_port_i == '0 && rd_offset_i == REG_OFS[R_TL] |=>
         rd_valid_o && rd_data_o == $past(transaction_layer_ctrl_o[0]))
      else $error("configuration read returned wrong data");
endmodule : ecl_cfg_loader

// *** ecl_cfg_loader_tb_top.sv ***
// ecl_cfg_loader_tb_top: loads one word set and reads every port image back
// assumes default signature and six ports
`timescale 1ns/100ps
module ecl_cfg_loader_tb_top;
   import ecl_pkg::*;
   logic clk_i = 1'b0, rst_i = 1'b1, ld = 1'b0, rq = 1'b0, mv, rv, done, bad, act;
   logic [7:0] ma, ro = 8'h0;
   logic [15:0] md;
   logic [2:0] rp = 3'h0;
   logic [1:0] pay;
   logic [31:0] rdat;
   int errors = 0, checked = 0;
   logic [7:0] wa [12] = '{8'h0c, 8'h0e, 8'h10, 8'h12, 8'h14, 8'h16, 8'h18, 8'h1a, 8'h1c, 8'h1e, 8'h20, 8'h16};
   logic [15:0] wd [12] = '{16'hf003, 16'h9234, 16'habcd, 16'h9a5a, 16'h5fa7, 16'h1111, 16'h2222, 16'h3333,
                            16'h4455, 16'h7abc, 16'h0066, 16'hffff};
   always #2 clk_i = ~clk_i;
   ecl_mem_model u_ecl_mem_model (.clk_i(clk_i), .mem_valid_o(mv), .mem_addr_o(ma), .mem_data_o(md));
   ecl_cfg_loader u_ecl_cfg_loader (.clk_i(clk_i), .rst_i(rst_i), .mem_valid_i(mv), .mem_addr_i(ma),
      .mem_data_i(md), .load_start_i(ld), .load_active_o(act), .load_done_o(done), .sig_bad_o(bad),
      .payload_size_o(pay), .rd_req_i(rq), .rd_port_i(rp), .rd_offset_i(ro), .rd_valid_o(rv),
      .rd_data_o(rdat), .interrupt_pin_info_o(), .phy_nominal_drive_o(), .phy_emphasis_fts_o(),
      .phy_latency_detect_o(), .vendor_phy_ctrl_a_o(), .vendor_phy_ctrl_b_o(), .transaction_layer_ctrl_o(),
      .phy_delta_params_o(), .phy_margin_drive_o(), .refclk_buffer_ctrl_o(), .link_capability_o(),
      .device_capability_two_o());
   task automatic chk(input string n, input logic [31:0] e, input logic [31:0] s);
      checked++;
      if (s !== e) begin
         errors++;
         $display("unexpected %s expected %h seen %h", n, e, s);
      end
   endtask : chk
   task automatic rd(input logic [2:0] p, input logic [7:0] o, input logic [31:0] e);
      @(posedge clk_i);
      #1;
      rq = 1'b1;
      rp = p;
      ro = o;
      @(posedge clk_i);
      #1;
      rq = 1'b0;
      chk("rd_valid", 32'h1, {31'h0, rv});
      chk("rd_data", e, rdat);
   endtask : rd
   function automatic logic [31:0] ex(input int p, input logic [7:0] o);
      case (o)
         8'h3c: ex = (p == 0) ? 32'h0 : 32'h100;
         8'h74: ex = 32'h2bcd0000;
         8'h78: ex = (p == 0) ? 32'h1a5a0066 : 32'h1a5a0000;
         8'h7c: ex = 32'h27;
         8'h84: ex = 32'h22221111;
         8'h88: ex = 32'h553333;
         8'h8c: ex = 32'h9c00100e;
         8'h90: ex = 32'habcf8000;
         8'h94: ex = 32'h1234;
         8'h98: ex = 32'h440000;
         8'hcc: ex = 32'h80000;
         8'he4: ex = 32'h41000;
         default: ex = 32'h0;
      endcase
   endfunction : ex
   task automatic results;
      if (errors == 0 && checked > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask : results
   initial begin
      #8000;
      errors++;
      results();
   end
   initial begin
      repeat (4) @(posedge clk_i);
      #1;
      rst_i = 1'b0;
      u_ecl_mem_model.send(8'h0c, 16'h0002);
      chk("payload", 32'h0, {30'h0, pay});
      u_ecl_mem_model.send(8'h00, 16'hc3a5);
      chk("load_active", 32'h1, {31'h0, act});
      foreach (wa[i]) u_ecl_mem_model.send(wa[i], wd[i]);
      u_ecl_mem_model.idle();
      chk("done", 32'h1, {31'h0, done});
      chk("load_active", 32'h0, {31'h0, act});
      chk("payload", 32'h3, {30'h0, pay});
      for (int p = 0; p < 6; p++)
         for (int i = 0; i < 12; i++) rd(p[2:0], REG_OFS[i], ex(p, REG_OFS[i]));
      rd(3'h6, 8'h8c, 32'h0);
      rd(3'h0, 8'h80, 32'h0);
      @(posedge clk_i);
      #1;
      ld = 1'b1;
      @(posedge clk_i);
      #1;
      ld = 1'b0;
      chk("done", 32'h0, {31'h0, done});
      u_ecl_mem_model.send(8'h00, 16'h0000);
      chk("sig_bad", 32'h1, {31'h0, bad});
      u_ecl_mem_model.send(8'h0c, 16'h0000);
      u_ecl_mem_model.idle();
      chk("payload", 32'h3, {30'h0, pay});
      results();
   end
endmodule : ecl_cfg_loader_tb_top

// *** ecl_mem_model.sv ***
// ecl_mem_model: configuration memory side, back-to-back words, one per send call
// assumes each call starts just after a rising edge and the loader samples on the next one
`timescale 1ns/100ps
module ecl_mem_model (
   // clock
   input wire logic clk_i,
   // word stream
   output logic mem_valid_o,
   output logic [7:0] mem_addr_o,
   output logic [15:0] mem_data_o
);
   initial begin
      mem_valid_o = 1'b0;
      mem_addr_o = 8'hff;
      mem_data_o = 16'h0;
   end
   task automatic send(input logic [7:0] a, input logic [15:0] d);
      mem_valid_o = 1'b1;
      mem_addr_o = a;
      mem_data_o = d;
      @(posedge clk_i);
      #1;
   endtask : send
   // released bus shows inverted data so a stale word cannot pass for a new one
   task automatic idle;
      mem_valid_o = 1'b0;
      mem_data_o = ~mem_data_o;
   endtask : idle
endmodule : ecl_mem_model

// *** ecl_pkg.sv ***
// ecl_pkg: constants shared by the configuration word loader and its per-port register images
// assumes every user runs on one core clock and imports the whole package
package ecl_pkg;
   localparam int REG_W = 32;
   localparam int MEM_W = 16;
   localparam int MEM_AW = 8;
   localparam int RD_PW = 3;
   localparam int NUM_REGS = 12;
   localparam int NUM_PORTS_DEF = 6;

   // register image indices
   localparam int R_INTR = 0;
   localparam int R_NOM = 1;
   localparam int R_EMP = 2;
   localparam int R_LAT = 3;
   localparam int R_VA = 4;
   localparam int R_VB = 5;
   localparam int R_TL = 6;
   localparam int R_DLT = 7;
   localparam int R_MGN = 8;
   localparam int R_BUF = 9;
   localparam int R_LNK = 10;
   localparam int R_DC2 = 11;

   // configuration offsets, index 0 rightmost
   localparam logic [NUM_REGS-1:0][7:0] REG_OFS = {8'he4, 8'hcc, 8'h98, 8'h94, 8'h90, 8'h8c,
                                                  8'h88, 8'h84, 8'h7c, 8'h78, 8'h74, 8'h3c};
   localparam logic [NUM_REGS-1:0][REG_W-1:0] REG_RST = '0;

   // memory word byte addresses
   localparam logic [MEM_AW-1:0] W_SIG = 8'h00;
   localparam logic [MEM_AW-1:0] W_CAP = 8'h0c;
   localparam logic [MEM_AW-1:0] W_MGN = 8'h0e;
   localparam logic [MEM_AW-1:0] W_NOM = 8'h10;
   localparam logic [MEM_AW-1:0] W_EMP = 8'h12;
   localparam logic [MEM_AW-1:0] W_LAT = 8'h14;
   localparam logic [MEM_AW-1:0] W_VA_LO = 8'h16;
   localparam logic [MEM_AW-1:0] W_VA_HI = 8'h18;
   localparam logic [MEM_AW-1:0] W_VB_LO = 8'h1a;
   localparam logic [MEM_AW-1:0] W_VB_HI = 8'h1c;
   localparam logic [MEM_AW-1:0] W_DLT = 8'h1e;
   localparam logic [MEM_AW-1:0] W_FTS = 8'h20;

   // target field positions
   localparam int CC_SDN = 19;
   localparam int TL_PMDS = 1;
   localparam int TL_ABT = 2;
   localparam int TL_4KB = 3;
   localparam int TL_GIDLE = 7;
   localparam int TL_ARB = 12;
   localparam int TL_MAC = 26;
   localparam int TL_G2 = 31;
   localparam int DC2_LTR = 12;
   localparam int DC2_OBFF = 18;
   localparam int INT_PIN = 8;
   localparam int HI_POS = 16;
   localparam int LO_POS = 0;
   localparam int RDET_POS = 4;
   localparam int HDLT_POS = 15;
   localparam int DLT_POS = 20;

   // source bit positions within a memory word
   localparam int S_SDN = 12;
   localparam int S_PMDS = 13;
   localparam int S_LTR = 14;
   localparam int S_TOP = 15;
   localparam int S_RDET = 4;
   localparam int S_HDLT = 7;
   localparam int S_ABT = 12;
   localparam int S_GIDLE = 13;
   localparam int S_ARB = 14;
   localparam int S_MAC = 12;
   localparam int S_BUF = 8;

   // field widths
   localparam int W_TRI = 15;
   localparam int W_LATF = 4;
   localparam int W_RDET = 3;
   localparam int W_HDLT = 5;
   localparam int W_BYTE = 8;
   localparam int W_DLTF = 12;
   localparam int W_MACF = 4;
   localparam int W_PAY = 2;

   typedef enum logic [1:0] {ECL_WAIT_SIG, ECL_LOAD, ECL_DONE, ECL_BAD} ecl_state_t;
endpackage : ecl_pkg

// *** ecl_port_regs.sv ***
// ecl_port_regs: register images of one switch port, merged from masked word updates
// assumes mask and value come from the loader decode in the same cycle as apply_i
`timescale 1ns/100ps
module ecl_port_regs #(
   parameter int PORT = 0
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // masked update
   input wire logic apply_i,
   input wire logic [ecl_pkg::NUM_REGS-1:0][ecl_pkg::REG_W-1:0] mask_i,
   input wire logic [ecl_pkg::NUM_REGS-1:0][ecl_pkg::REG_W-1:0] val_i,
   // register images
   output logic [ecl_pkg::NUM_REGS-1:0][ecl_pkg::REG_W-1:0] regs_o
);
   import ecl_pkg::*;

   typedef struct packed {
      logic [NUM_REGS-1:0][REG_W-1:0] regs;
   } ecl_port_state_t;

   ecl_port_state_t q;
   ecl_port_state_t next_q;
   logic [NUM_REGS-1:0][REG_W-1:0] m;

   always_comb begin
      m = mask_i;
      if (PORT == 0) begin
         m[R_INTR][INT_PIN] = 1'b0;
      end else begin
         m[R_EMP][LO_POS +: W_BYTE] = '0;
      end
      next_q = q;
      if (apply_i) begin
         for (int r = 0; r < NUM_REGS; r++) begin
            next_q.regs[r] = (q.regs[r] & ~m[r]) | (val_i[r] & m[r]);
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{regs: REG_RST};
      end else begin
         q <= next_q;
      end
   end

   assign regs_o = q.regs;
endmodule : ecl_port_regs

// *** ecl_rd_port.sv ***
// ecl_rd_port: registered configuration read of one port's register image by offset
// assumes requests and images are on the core clock; unmapped offsets or ports read zero
`timescale 1ns/100ps
module ecl_rd_port #(
   parameter int NUM_PORTS = ecl_pkg::NUM_PORTS_DEF
) (
   // clock and reset
   input wire logic clk_i,
   input wire logic rst_i,
   // request
   input wire logic rd_req_i,
   input wire logic [ecl_pkg::RD_PW-1:0] rd_port_i,
   input wire logic [7:0] rd_offset_i,
   input wire logic [NUM_PORTS-1:0][ecl_pkg::NUM_REGS-1:0][ecl_pkg::REG_W-1:0] regs_i,
   // answer
   output logic rd_valid_o,
   output logic [ecl_pkg::REG_W-1:0] rd_data_o
);
   import ecl_pkg::*;

   typedef struct packed {
      logic valid;
      logic [REG_W-1:0] data;
   } ecl_rd_state_t;

   ecl_rd_state_t q;
   ecl_rd_state_t next_q;

   always_comb begin
      next_q = q;
      next_q.valid = rd_req_i;
      if (rd_req_i) begin
         next_q.data = '0;
         for (int p = 0; p < NUM_PORTS; p++) begin
            for (int r = 0; r < NUM_REGS; r++) begin
               if (int'(rd_port_i) == p && rd_offset_i == REG_OFS[r]) begin
                  next_q.data = regs_i[p][r];
               end
            end
         end
      end
   end

   always_ff @(posedge clk_i or posedge rst_i) begin
      if (rst_i) begin
         q <= '{valid: 1'b0, data: '0};
      end else begin
         q <= next_q;
      end
   end

   assign rd_valid_o = q.valid;
   assign rd_data_o = q.data;
endmodule : ecl_rd_port
